// file: bench/mcaux_core_test.sv
// Self-checking bench for the auxiliary functions of one microcore.
// Inputs change at falling edges; mcaux_target_model answers the backdoor.
`timescale 1ns/1ps
module mcaux_core_test;
    logic clk = 1'b0, reset = 1'b1, instr_valid = 1'b0, core_unlocked = 1'b0, lock = 1'b0;
    mcaux_pkg::mcaux_op_t instr_op = mcaux_pkg::OP_NOP;
    logic [15:0] instr_data = 16'h0000, own_flags, flag_bus, status_bits, spi_data, bd_rd_data, bd_wr_data, bd_wr_mask;
    logic [11:0] output_access_config = 12'h000, diag_enable;
    logic [9:0] program_counter = 10'h000, aux_reg;
    logic [7:0] bd_addr, index_register = 8'h00;
    logic [3:0] instr_bit_sel = 4'h0;
    logic [15:0] flag_combine_sel = 16'h0000;
    logic [47:0] other_flags = {48{1'b1}};
    logic vsrc_force_zero, offset_recover_4h;
    logic interrupt_request_pin_n, threshold_compare_en, dcdc_mode, bd_busy, bd_rd_en, bd_wr_en, bd_target_locked;
    int error_cnt = 0;
    int num_checks = 0;
    initial forever #5 clk = ~clk;
    mcaux_core mcaux_core_inst (
        .clk, .reset, .instr_valid, .instr_op, .instr_data, .instr_bit_sel, .program_counter,
        .index_register, .core_unlocked, .output_access_config, .cur_access_config(5'h00),
        .other_flags, .flag_combine_sel, .own_flags, .flag_bus, .diag_enable,
        .interrupt_request_pin_n, .aux_reg, .offset_comp_en(), .offset_recover_4h, .offset_comp_4neg(),
        .gain_sel(), .adc_mode(), .threshold_compare_en, .status_bits, .dcdc_mode, .eoa_mode(), .vsrc_force_zero,
        .bd_addr_src_index(), .spi_addr(), .spi_data, .bd_busy, .bd_addr, .bd_rd_en, .bd_rd_data,
        .bd_target_locked, .bd_wr_en, .bd_wr_data, .bd_wr_mask);
    mcaux_target_model mcaux_target_model_inst (.clk, .bd_addr, .bd_rd_en, .bd_wr_en, .bd_wr_data, .bd_wr_mask,
        .lock, .bd_rd_data, .bd_target_locked);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Returns at the falling edge after the taking edge, so results are visible
    task automatic op(input mcaux_pkg::mcaux_op_t c, input logic [15:0] d);
        @(negedge clk);
        instr_valid = 1'b1;
        instr_op = c;
        instr_data = d;
        @(negedge clk);
        instr_valid = 1'b0;
    endtask : op
    task automatic t_irq_jsr;
        op(mcaux_pkg::OP_STIRQ, 16'h0001);
        chk(16'(interrupt_request_pin_n), 16'h0000);
        program_counter = 10'h2A5;
        op(mcaux_pkg::OP_JSR, 16'h0000);
        chk(16'(aux_reg), 16'h02A5);
    endtask : t_irq_jsr
    task automatic t_modes;
        output_access_config = 12'h0F0;
        op(mcaux_pkg::OP_ENDIAG, 16'h0FFF);
        chk(16'(diag_enable), 16'h00F0);
        op(mcaux_pkg::OP_DCDC, 16'h0001);
        chk(16'(dcdc_mode), 16'h0000);
        op(mcaux_pkg::OP_STADC, 16'h0001);
        chk(16'(threshold_compare_en), 16'h0000);
        op(mcaux_pkg::OP_ST_WORD, 16'hA5C3);
        chk(status_bits, 16'hA5C3);
        instr_bit_sel = 4'h2;
        op(mcaux_pkg::OP_ST_BIT, 16'h0001);
        chk(status_bits, 16'hA5C7);
        op(mcaux_pkg::OP_STOC, 16'h0008);
        chk(16'(offset_recover_4h), 16'h0001);
        op(mcaux_pkg::OP_EOA, 16'h0003);
        chk(16'(vsrc_force_zero), 16'h0001);
        output_access_config = 12'h800;
        op(mcaux_pkg::OP_DCDC, 16'h0001);
        chk(16'(dcdc_mode), 16'h0001);
    endtask : t_modes
    task automatic t_flags;
        op(mcaux_pkg::OP_STFLAG, 16'h1234);
        chk(own_flags, 16'h1234);
        @(negedge clk);
        chk(flag_bus, 16'h1234);
        other_flags = {32'hFFFF_FFFF, 16'h00FF};
        flag_combine_sel = 16'h0F0F;
        @(negedge clk);
        chk(flag_bus, 16'h1034);
        flag_combine_sel = 16'h0000;
        core_unlocked = 1'b1;
        @(negedge clk);
        chk(own_flags, 16'hFFFF);
        chk(flag_bus, 16'hFFFF);
        core_unlocked = 1'b0;
    endtask : t_flags
    task automatic t_backdoor;
        output_access_config = 12'h005;
        op(mcaux_pkg::OP_LD_BDADDR, 16'h008E);
        op(mcaux_pkg::OP_LD_BDDATA, 16'hFFFF);
        op(mcaux_pkg::OP_WRSPI, 16'h0000);
        chk(bd_wr_mask, 16'h0033);
        @(negedge clk);
        chk(16'(bd_busy), 16'h0000);
        lock = 1'b1;
        op(mcaux_pkg::OP_LD_BDDATA, 16'h0000);
        op(mcaux_pkg::OP_WRSPI, 16'h0000);
        chk(16'(bd_wr_en), 16'h0000);
        lock = 1'b0;
        @(negedge clk);
        op(mcaux_pkg::OP_RDSPI, 16'h0000);
        @(negedge clk);
        chk(spi_data, 16'h0033);
        op(mcaux_pkg::OP_LD_BDADDR, 16'h0090);
        op(mcaux_pkg::OP_RDSPI, 16'h0000);
        @(negedge clk);
        chk(spi_data, 16'h0000);
        index_register = 8'h8E;
        op(mcaux_pkg::OP_SLSA, 16'h0001);
        op(mcaux_pkg::OP_RDSPI, 16'h0000);
        @(negedge clk);
        chk(spi_data, 16'h0033);
    endtask : t_backdoor
    task automatic summarize;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    // Whole run is well under a hundred cycles
    initial begin
        repeat (2000) @(posedge clk);
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (16) @(negedge clk);
        reset = 1'b0;
        chk(flag_bus, 16'hFFFF);
        t_irq_jsr();
        t_modes();
        t_flags();
        t_backdoor();
        summarize();
    end
endmodule : mcaux_core_test

// file: bench/mcaux_target_model.sv
// Register file standing behind the backdoor port of one microcore.
// Assumes one-cycle read and write strobes; read data is answered in the strobe cycle.
`timescale 1ns/1ps
module mcaux_target_model (
    // Backdoor port
    input  wire logic        clk,
    input  wire logic [7:0]  bd_addr,
    input  wire logic        bd_rd_en,
    input  wire logic        bd_wr_en,
    input  wire logic [15:0] bd_wr_data,
    input  wire logic [15:0] bd_wr_mask,
    input  wire logic        lock,
    output logic [15:0]      bd_rd_data,
    output logic             bd_target_locked
);
    logic [15:0] mem [256];
    logic [15:0] last_reg = 16'h0000;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'h0000;
        end
    end
    assign bd_target_locked = lock;
    // Outside a read the bus shows junk, never a stale value
    assign bd_rd_data = bd_rd_en ? mem[bd_addr] : ~last_reg;
    always @(posedge clk) begin
        if (bd_rd_en) begin
            last_reg <= mem[bd_addr];
        end
        if (bd_wr_en) begin
            mem[bd_addr] <= (mem[bd_addr] & ~bd_wr_mask) | (bd_wr_data & bd_wr_mask);
        end
    end
endmodule : mcaux_target_model

// file: src/mcaux_bd_filter.sv
// Computes the writable-bit mask of a backdoor target from the core's access rights.
// Assumes the address is the low eight bits of the register address, held stable.
`timescale 1ns/1ps
module mcaux_bd_filter (
    // Target
    input  logic [7:0]                     addr,
    // Access rights of this core
    input  logic [mcaux_pkg::NUM_OUT-1:0]  out_acc,
    input  logic [mcaux_pkg::NUM_CACC-1:0] cur_acc,
    // Result
    output logic [15:0]                    wr_mask,
    output logic                           dac_blocked
);

    logic [15:0] m_vds_hs;
    logic [15:0] m_vds_ls1;
    logic [15:0] m_vds_ls2;
    logic [15:0] m_hs_slew;
    logic [15:0] m_ls_slew;
    logic [15:0] m_bias;

    genvar i;
    generate
        for (i = 0; i < mcaux_pkg::NUM_HS; i++) begin : g_hs
            assign m_vds_hs[i*mcaux_pkg::THR_W +: mcaux_pkg::THR_W]   = {mcaux_pkg::THR_W{out_acc[i]}};
            assign m_vds_ls1[i*mcaux_pkg::THR_W +: mcaux_pkg::THR_W]  = {mcaux_pkg::THR_W{out_acc[mcaux_pkg::NUM_HS+i]}};
            assign m_hs_slew[i*mcaux_pkg::SLEW_W +: mcaux_pkg::SLEW_W] = {mcaux_pkg::SLEW_W{out_acc[i]}};
        end
        for (i = 0; i < mcaux_pkg::NUM_LS; i++) begin : g_ls
            assign m_ls_slew[i*mcaux_pkg::SLEW_W +: mcaux_pkg::SLEW_W] = {mcaux_pkg::SLEW_W{out_acc[mcaux_pkg::NUM_HS+i]}};
        end
    endgenerate
    assign m_vds_hs[15]   = 1'b0;
    assign m_vds_ls1[15]  = 1'b0;
    assign m_vds_ls2      = {10'h000, {3{out_acc[mcaux_pkg::NUM_HS+6]}}, {3{out_acc[mcaux_pkg::NUM_HS+5]}}};
    assign m_hs_slew[15:10] = 6'h00;
    assign m_ls_slew[15:14] = 2'h0;
    assign m_bias         = {4'h0, out_acc};

    wire [15:0] m_f12  = {{8{cur_acc[1]}}, {8{cur_acc[0]}}};
    wire [15:0] m_f34  = {{8{cur_acc[3]}}, {8{cur_acc[2]}}};
    wire [15:0] m_f4hn = {16{cur_acc[3]}};
    wire [15:0] m_bflt = {16{cur_acc[mcaux_pkg::BOOST_IDX]}};

    // Threshold converters, boost included, are never reachable
    assign dac_blocked = (addr >= mcaux_pkg::ADDR_DAC_FIRST && addr <= mcaux_pkg::ADDR_DAC_LAST)
                       || addr == mcaux_pkg::ADDR_BOOST_DAC;

    assign wr_mask = dac_blocked                             ? 16'h0000 :
                     (addr == mcaux_pkg::ADDR_VDS_HS ||
                      addr == mcaux_pkg::ADDR_VSRC_HS)       ? m_vds_hs :
                     (addr == mcaux_pkg::ADDR_VDS_LS1)       ? m_vds_ls1 :
                     (addr == mcaux_pkg::ADDR_VDS_LS2)       ? m_vds_ls2 :
                     (addr == mcaux_pkg::ADDR_HS_SLEW)       ? m_hs_slew :
                     (addr == mcaux_pkg::ADDR_LS_SLEW)       ? m_ls_slew :
                     (addr == mcaux_pkg::ADDR_BIAS)          ? m_bias :
                     (addr == mcaux_pkg::ADDR_CFILT12)       ? m_f12 :
                     (addr == mcaux_pkg::ADDR_CFILT34L)      ? m_f34 :
                     (addr == mcaux_pkg::ADDR_CFILT4H4N)     ? m_f4hn :
                     (addr == mcaux_pkg::ADDR_BOOST_FLT)     ? m_bflt :
                     mcaux_pkg::FULL_MASK;

endmodule : mcaux_bd_filter

// file: src/mcaux_core.sv
// Auxiliary execution functions of one microcore: diagnosis, flags, irq, subroutine store,
// current measure control, status bits, register backdoor, DC-DC and end-of-actuation modes.
// Assumes one decoded instruction per cycle from the sequencer, all inputs synchronous to clk.
// Function
// - Diagnosis enable changes only outputs this core may drive.
// - Each core drives a sixteen-bit flag bus set by instruction.
// - Flags of all four cores merge per combining configuration.
// - Flags active low, reset to one, held at one while core unlocked.
// - Interrupt-set instruction drives the interrupt request and its pin.
// - Jump to subroutine stores the program counter in the auxiliary register.
// - Offset compensation switch applies to the first four threshold converters only.
// - Fourth high converter reuses fourth low offset; negative one gets none.
// - Gain-set instruction changes the shunt amplifier gain.
// - Conversion request enters conversion mode, disabling threshold comparisons.
// - Status writes set the whole sixteen-bit word or one selected bit.
// - Backdoor address comes from backdoor address register or index register.
// - Backdoor reaches every register-mapped target except code and data memory and the threshold converter registers.
// - Backdoor read returns target data into the backdoor data register.
// - Backdoor write sends backdoor data to the addressed register.
// - Backdoor operations take two cycles; address and data held meanwhile.
// - Unused backdoor address and data registers serve as spare storage.
// - Backdoor write discarded if target locked when the request issues.
// - Threshold, edge rate and bias writes touch only permitted driver fields.
// - Filter writes touch only setups of permitted converters.
// - Threshold converter registers, boost included, are unreachable by backdoor.
// - DC-DC mode enabled only with rights to the seventh low-side output.
// - End-of-actuation mode may also force the high-side source threshold to zero.
`timescale 1ns/1ps
module mcaux_core #(
    parameter int PC_W   = 10,
    parameter int GAIN_W = 2
) (
    // Clock and reset
    input  logic                           clk,
    input  logic                           reset,
    // Decoded instruction
    input  logic                           instr_valid,
    input  mcaux_pkg::mcaux_op_t           instr_op,
    input  logic [15:0]                    instr_data,
    input  logic [3:0]                     instr_bit_sel,
    // Sequencer context
    input  logic [PC_W-1:0]                program_counter,
    input  logic [7:0]                     index_register,
    input  logic                           core_unlocked,
    // Access configuration
    input  logic [mcaux_pkg::NUM_OUT-1:0]  output_access_config,
    input  logic [mcaux_pkg::NUM_CACC-1:0] cur_access_config,
    // Flags
    input  logic [47:0]                    other_flags,
    input  logic [15:0]                    flag_combine_sel,
    output logic [15:0]                    own_flags,
    output logic [15:0]                    flag_bus,
    // Diagnosis and interrupt
    output logic [mcaux_pkg::NUM_OUT-1:0]  diag_enable,
    output logic                           interrupt_request_pin_n,
    output logic [PC_W-1:0]                aux_reg,
    // Current measure control
    output logic [mcaux_pkg::NUM_DAC-1:0]  offset_comp_en,
    output logic                           offset_recover_4h,
    output logic                           offset_comp_4neg,
    output logic [GAIN_W-1:0]              gain_sel,
    output logic                           adc_mode,
    output logic                           threshold_compare_en,
    // Status and configuration
    output logic [15:0]                    status_bits,
    output logic                           dcdc_mode,
    output logic                           eoa_mode,
    output logic                           vsrc_force_zero,
    // Backdoor storage
    output logic                           bd_addr_src_index,
    output logic [7:0]                     spi_addr,
    output logic [15:0]                    spi_data,
    output logic                           bd_busy,
    // Backdoor register port
    output logic [7:0]                     bd_addr,
    output logic                           bd_rd_en,
    input  logic [15:0]                    bd_rd_data,
    input  logic                           bd_target_locked,
    output logic                           bd_wr_en,
    output logic [15:0]                    bd_wr_data,
    output logic [15:0]                    bd_wr_mask
);

    // Instruction decode
    wire is_op     = instr_valid;
    wire op_endiag = is_op && instr_op == mcaux_pkg::OP_ENDIAG;
    wire op_flag   = is_op && instr_op == mcaux_pkg::OP_STFLAG;
    wire op_irq    = is_op && instr_op == mcaux_pkg::OP_STIRQ;
    wire op_jsr    = is_op && instr_op == mcaux_pkg::OP_JSR;
    wire op_oc     = is_op && instr_op == mcaux_pkg::OP_STOC;
    wire op_gain   = is_op && instr_op == mcaux_pkg::OP_STGN;
    wire op_adc    = is_op && instr_op == mcaux_pkg::OP_STADC;
    wire op_sword  = is_op && instr_op == mcaux_pkg::OP_ST_WORD;
    wire op_sbit   = is_op && instr_op == mcaux_pkg::OP_ST_BIT;
    wire op_slsa   = is_op && instr_op == mcaux_pkg::OP_SLSA;
    wire op_dcdc   = is_op && instr_op == mcaux_pkg::OP_DCDC;
    wire op_eoa    = is_op && instr_op == mcaux_pkg::OP_EOA;
    // Loads and requests are refused while the backdoor runs, keeping its operands steady
    wire op_ldaddr = is_op && instr_op == mcaux_pkg::OP_LD_BDADDR && !bd_busy;
    wire op_lddata = is_op && instr_op == mcaux_pkg::OP_LD_BDDATA && !bd_busy;
    wire op_rd     = is_op && instr_op == mcaux_pkg::OP_RDSPI && !bd_busy;
    wire op_wr     = is_op && instr_op == mcaux_pkg::OP_WRSPI && !bd_busy;

    // Simple control registers
    logic [mcaux_pkg::NUM_OUT-1:0] diag_reg;
    logic [15:0]                   flags_reg;
    logic                          irq_n_reg;
    logic [PC_W-1:0]               aux_reg_q;
    logic [mcaux_pkg::NUM_DAC-1:0] oc_reg;
    logic [GAIN_W-1:0]             gain_reg;
    logic                          adc_reg;
    logic [15:0]                   status_reg;
    logic                          dcdc_reg;
    logic                          eoa_reg;
    logic                          eoa_auto_reg;
    logic                          src_idx_reg;

    wire [mcaux_pkg::NUM_OUT-1:0] diag_next =
        (diag_reg & ~output_access_config) | (instr_data[mcaux_pkg::NUM_OUT-1:0] & output_access_config);
    wire [15:0] bit_onehot  = 16'h0001 << instr_bit_sel;
    wire [15:0] status_bitv = instr_data[0] ? (status_reg | bit_onehot) : (status_reg & ~bit_onehot);
    wire        dcdc_ok     = output_access_config[mcaux_pkg::LS7_IDX];

    always_ff @(posedge clk) begin
        if (reset) begin
            diag_reg     <= '0;
            flags_reg    <= mcaux_pkg::FLAGS_RST;
            irq_n_reg    <= 1'b1;
            aux_reg_q    <= '0;
            oc_reg       <= '0;
            gain_reg     <= '0;
            adc_reg      <= 1'b0;
            status_reg   <= mcaux_pkg::STATUS_RST;
            dcdc_reg     <= 1'b0;
            eoa_reg      <= 1'b0;
            eoa_auto_reg <= 1'b0;
            src_idx_reg  <= 1'b0;
        end else begin
            if (op_endiag) diag_reg <= diag_next;
            if (op_flag) flags_reg <= instr_data;
            if (op_irq) irq_n_reg <= ~instr_data[0];
            if (op_jsr) aux_reg_q <= program_counter;
            if (op_oc) oc_reg <= instr_data[mcaux_pkg::NUM_DAC-1:0];
            if (op_gain) gain_reg <= instr_data[GAIN_W-1:0];
            if (op_adc) adc_reg <= instr_data[0];
            if (op_sword) status_reg <= instr_data;
            else if (op_sbit) status_reg <= status_bitv;
            if (op_dcdc && dcdc_ok) dcdc_reg <= instr_data[0];
            if (op_eoa) begin
                eoa_reg      <= instr_data[0];
                eoa_auto_reg <= instr_data[1];
            end
            if (op_slsa) src_idx_reg <= instr_data[0];
        end
    end

    // Flags: unlocked core stays inactive so others are undisturbed
    wire [15:0] own_eff = core_unlocked ? mcaux_pkg::FLAGS_RST : flags_reg;
    wire [15:0] merged;
    logic [15:0] flag_bus_reg;

    mcaux_flag_merge #(
        .FLAG_W (16)
    ) u_merge (
        .own_flags    (own_eff),
        .other_flags  (other_flags),
        .combine_sel  (flag_combine_sel),
        .merged_flags (merged)
    );

    always_ff @(posedge clk) begin
        if (reset) flag_bus_reg <= mcaux_pkg::FLAGS_RST;
        else flag_bus_reg <= merged;
    end

    // Backdoor
    mcaux_pkg::mcaux_bd_state_t bd_state_reg;
    mcaux_pkg::mcaux_bd_state_t bd_state_next;
    logic [7:0]  spi_addr_reg;
    logic [15:0] spi_data_reg;
    logic [7:0]  bd_addr_reg;
    logic [15:0] bd_mask_reg;
    logic        bd_locked_reg;
    logic        bd_blocked_reg;

    wire [7:0]  bd_addr_sel = src_idx_reg ? index_register : spi_addr_reg;
    wire [15:0] filt_mask;
    wire        filt_blocked;

    // Addresses are eight bits wide, so code and data memory cannot be named here
    mcaux_bd_filter u_filter (
        .addr        (bd_addr_sel),
        .out_acc     (output_access_config),
        .cur_acc     (cur_access_config),
        .wr_mask     (filt_mask),
        .dac_blocked (filt_blocked)
    );

    always_comb begin
        bd_state_next = bd_state_reg;
        unique case (bd_state_reg)
            mcaux_pkg::BD_IDLE: begin
                if (op_rd) bd_state_next = mcaux_pkg::BD_READ;
                else if (op_wr) bd_state_next = mcaux_pkg::BD_WRITE;
            end
            mcaux_pkg::BD_READ:  bd_state_next = mcaux_pkg::BD_IDLE;
            mcaux_pkg::BD_WRITE: bd_state_next = mcaux_pkg::BD_IDLE;
            default:             bd_state_next = mcaux_pkg::BD_IDLE;
        endcase
    end

    wire in_read  = bd_state_reg == mcaux_pkg::BD_READ;
    wire in_write = bd_state_reg == mcaux_pkg::BD_WRITE;

    always_ff @(posedge clk) begin
        if (reset) begin
            bd_state_reg   <= mcaux_pkg::BD_IDLE;
            spi_addr_reg   <= '0;
            spi_data_reg   <= '0;
            bd_addr_reg    <= '0;
            bd_mask_reg    <= '0;
            bd_locked_reg  <= 1'b0;
            bd_blocked_reg <= 1'b0;
        end else begin
            bd_state_reg <= bd_state_next;
            if (op_ldaddr) spi_addr_reg <= instr_data[7:0];
            if (op_lddata) spi_data_reg <= instr_data;
            else if (in_read) spi_data_reg <= bd_blocked_reg ? 16'h0000 : bd_rd_data;
            if (op_rd || op_wr) begin
                bd_addr_reg    <= bd_addr_sel;
                bd_mask_reg    <= filt_mask;
                bd_locked_reg  <= op_wr && bd_target_locked;
                bd_blocked_reg <= filt_blocked;
            end
        end
    end

    // Outputs
    assign bd_busy   = bd_state_reg != mcaux_pkg::BD_IDLE;
    assign bd_addr   = bd_addr_reg;
    assign bd_rd_en  = in_read && !bd_blocked_reg;
    assign bd_wr_en  = in_write && !bd_locked_reg && !bd_blocked_reg;
    assign bd_wr_data = spi_data_reg;
    assign bd_wr_mask = bd_mask_reg;

    assign own_flags               = own_eff;
    assign flag_bus                = flag_bus_reg;
    assign diag_enable             = diag_reg;
    assign interrupt_request_pin_n = irq_n_reg;
    assign aux_reg                 = aux_reg_q;
    assign offset_comp_en          = oc_reg;
    assign offset_recover_4h       = oc_reg[mcaux_pkg::NUM_DAC-1];
    assign offset_comp_4neg        = 1'b0;
    assign gain_sel                = gain_reg;
    assign adc_mode                = adc_reg;
    assign threshold_compare_en    = !adc_reg;
    assign status_bits             = status_reg;
    assign dcdc_mode               = dcdc_reg;
    assign eoa_mode                = eoa_reg;
    assign vsrc_force_zero         = eoa_reg && eoa_auto_reg;
    assign bd_addr_src_index       = src_idx_reg;
    assign spi_addr                = spi_addr_reg;
    assign spi_data                = spi_data_reg;

    // Checks
    property p_diag_keep;
        @(posedge clk) disable iff (reset)
        op_endiag |=> ((diag_enable & ~$past(output_access_config)) == ($past(diag_enable) & ~$past(output_access_config)));
    endproperty
    a_diag_keep: assert property (p_diag_keep) else $error("diag changed on a foreign output");

    property p_flag_unlocked;
        @(posedge clk) disable iff (reset)
        (core_unlocked && flag_combine_sel == 16'h0000) |=> flag_bus == 16'hFFFF;
    endproperty
    a_flag_unlocked: assert property (p_flag_unlocked) else $error("unlocked core drove an active flag");

    property p_irq_set;
        @(posedge clk) disable iff (reset)
        op_irq |=> interrupt_request_pin_n == !$past(instr_data[0]);
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("irq pin does not follow parameter");

    property p_jsr_store;
        @(posedge clk) disable iff (reset)
        op_jsr |=> aux_reg == $past(program_counter);
    endproperty
    a_jsr_store: assert property (p_jsr_store) else $error("return address not stored");

    property p_adc_mode;
        @(posedge clk) disable iff (reset)
        (op_adc && instr_data[0]) |=> adc_mode && !threshold_compare_en;
    endproperty
    a_adc_mode: assert property (p_adc_mode) else $error("comparisons active in conversion mode");

    property p_bd_two_cycles;
        @(posedge clk) disable iff (reset)
        (op_rd || op_wr) |=> bd_busy ##1 !bd_busy;
    endproperty
    a_bd_two_cycles: assert property (p_bd_two_cycles) else $error("backdoor op not two cycles");

    property p_wr_locked;
        @(posedge clk) disable iff (reset)
        (op_wr && bd_target_locked) |=> !bd_wr_en [*2];
    endproperty
    a_wr_locked: assert property (p_wr_locked) else $error("write to locked register");

    property p_dcdc_rights;
        @(posedge clk) disable iff (reset)
        (op_dcdc && !dcdc_ok) |=> $stable(dcdc_mode);
    endproperty
    a_dcdc_rights: assert property (p_dcdc_rights) else $error("dcdc changed without rights");

    property p_rd_result;
        @(posedge clk) disable iff (reset)
        (in_read && !bd_blocked_reg) |=> spi_data == $past(bd_rd_data);
    endproperty
    a_rd_result: assert property (p_rd_result) else $error("read result not captured");

    property p_dac_blocked;
        @(posedge clk) disable iff (reset)
        (op_wr && filt_blocked) |=> !bd_wr_en && bd_wr_mask == 16'h0000;
    endproperty
    a_dac_blocked: assert property (p_dac_blocked) else $error("threshold converter reached");

endmodule : mcaux_core

// file: src/mcaux_flag_merge.sv
// Merges the flag buses of all four microcores into one bus.
// Assumes every source is active low and already forced high when its core is unlocked.
`timescale 1ns/1ps
module mcaux_flag_merge #(
    parameter int FLAG_W = 16
) (
    // Flag sources
    input  logic [FLAG_W-1:0]   own_flags,
    input  logic [3*FLAG_W-1:0] other_flags,
    // Combining configuration: 1 merges all cores, 0 keeps the own core
    input  logic [FLAG_W-1:0]   combine_sel,
    // Result
    output logic [FLAG_W-1:0]   merged_flags
);

    genvar b;
    generate
        for (b = 0; b < FLAG_W; b++) begin : g_bit
            // Active low, so an AND lets any core pull the flag
            wire all_low = own_flags[b] & other_flags[b] & other_flags[FLAG_W+b] & other_flags[2*FLAG_W+b];
            assign merged_flags[b] = combine_sel[b] ? all_low : own_flags[b];
        end
    endgenerate

endmodule : mcaux_flag_merge

// file: src/mcaux_pkg.sv
// Constants, instruction codes and backdoor address map for the microcore auxiliary functions.
// Assumes the sequencer decodes microcode into one mcaux_op_t per cycle.
package mcaux_pkg;

    // Outputs: high sides occupy the low bits, then the low sides
    localparam int NUM_HS  = 5;
    localparam int NUM_LS  = 7;
    localparam int NUM_OUT = NUM_HS + NUM_LS;
    localparam int LS7_IDX = NUM_HS + 6;

    // Threshold converters: four current converters plus the boost converter
    localparam int NUM_DAC   = 4;
    localparam int BOOST_IDX = 4;
    localparam int NUM_CACC  = 5;

    // Field layouts of the filtered registers
    localparam int THR_W  = 3;
    localparam int SLEW_W = 2;
    localparam int FILT_W = 8;

    // Reset values and the full write mask
    localparam logic [15:0] FLAGS_RST  = 16'hFFFF;
    localparam logic [15:0] FULL_MASK  = 16'hFFFF;
    localparam logic [15:0] STATUS_RST = 16'h0000;

    // Low eight bits of backdoor register addresses, both filtered and blocked
    localparam logic [7:0] ADDR_VDS_HS    = 8'h8A;
    localparam logic [7:0] ADDR_VSRC_HS   = 8'h8B;
    localparam logic [7:0] ADDR_VDS_LS1   = 8'h8C;
    localparam logic [7:0] ADDR_VDS_LS2   = 8'h8D;
    localparam logic [7:0] ADDR_HS_SLEW   = 8'h8E;
    localparam logic [7:0] ADDR_LS_SLEW   = 8'h8F;
    localparam logic [7:0] ADDR_BIAS      = 8'h88;
    localparam logic [7:0] ADDR_CFILT12   = 8'h98;
    localparam logic [7:0] ADDR_CFILT34L  = 8'h99;
    localparam logic [7:0] ADDR_CFILT4H4N = 8'h9A;
    localparam logic [7:0] ADDR_BOOST_DAC = 8'h9B;
    localparam logic [7:0] ADDR_BOOST_FLT = 8'h9D;
    localparam logic [7:0] ADDR_DAC_FIRST = 8'h90;
    localparam logic [7:0] ADDR_DAC_LAST  = 8'h94;

    // Instruction codes seen by the auxiliary block
    typedef enum logic [4:0] {
        OP_NOP       = 5'h00,
        OP_ENDIAG    = 5'h01,
        OP_STFLAG    = 5'h02,
        OP_STIRQ     = 5'h03,
        OP_JSR       = 5'h04,
        OP_STOC      = 5'h05,
        OP_STGN      = 5'h06,
        OP_STADC     = 5'h07,
        OP_ST_WORD   = 5'h08,
        OP_ST_BIT    = 5'h09,
        OP_SLSA      = 5'h0A,
        OP_LD_BDADDR = 5'h0B,
        OP_LD_BDDATA = 5'h0C,
        OP_RDSPI     = 5'h0D,
        OP_WRSPI     = 5'h0E,
        OP_DCDC      = 5'h0F,
        OP_EOA       = 5'h10
    } mcaux_op_t;

    // Backdoor sequencer, Gray along idle-read and idle-write
    typedef enum logic [1:0] {
        BD_IDLE  = 2'h0,
        BD_READ  = 2'h1,
        BD_WRITE = 2'h2
    } mcaux_bd_state_t;

endpackage : mcaux_pkg
